// file: hw/damping_if.sv
// Bandwidth and damping code to damping factor lookup carrier
`timescale 1ns/1ps
interface damping_if;
   import dpll_trim_pkg::*;
   logic [3:0] bandwidth;
   logic [2:0] code;
   damp_e factor;
   modport lookup (input bandwidth, input code, output factor);
   modport user (output bandwidth, output code, input factor);
endinterface : damping_if

// file: hw/damping_select.sv
// Damping factor chosen from damping code and bandwidth setting
`timescale 1ns/1ps
module damping_select (
   damping_if.lookup dif
);
   import dpll_trim_pkg::*;

   always_comb begin
      dif.factor = DAMP_5;
      unique case (dif.bandwidth)
         BW_CODE_8HZ: begin
            if (dif.code == 3'h1) dif.factor = DAMP_2P5;
         end
         BW_CODE_18HZ: begin
            if (dif.code == 3'h1) dif.factor = DAMP_1P2;
            else if (dif.code == 3'h2) dif.factor = DAMP_2P5;
         end
         BW_CODE_35HZ: begin
            if (dif.code == 3'h1) dif.factor = DAMP_1P2;
            else if (dif.code == 3'h2) dif.factor = DAMP_2P5;
            else if (dif.code == 3'h4 || dif.code == 3'h5)
               dif.factor = DAMP_10;
         end
         BW_CODE_70HZ: begin
            if (dif.code == 3'h1) dif.factor = DAMP_1P2;
            else if (dif.code == 3'h2) dif.factor = DAMP_2P5;
            else if (dif.code == 3'h4) dif.factor = DAMP_10;
            else if (dif.code == 3'h5) dif.factor = DAMP_20;
         end
         default: begin
            // Up to 4 Hz, and codes above 70 Hz, keep damping 5
            dif.factor = DAMP_5;
         end
      endcase
   end
endmodule : damping_select

// file: hw/dpll_loop_and_xo_trim.sv
// DPLL loop bandwidth, damping and oscillator frequency trim control
//
// Overview of operation
// - Damping factor from damping code and bandwidth
// - Trim word built from two byte writes
// - Each trim step shifts outputs 0.0196229 ppm
// - Trim resets to 9999 hex, zero offset
// - Every trim value 0 to 65535 accepted
// - Loop switches acquisition and locked bandwidth automatically
// - Loop low-passes phase, pole set by bandwidth
// - Acquisition bandwidth while unlocked, locked bandwidth after
// - Automatic mode off: only locked bandwidth used
`timescale 1ns/1ps
module dpll_loop_and_xo_trim #(
   parameter int PHASE_W = 16
) (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic [dpll_trim_pkg::BW_W-1:0] acquisition_bandwidth_setting,
   input wire logic [dpll_trim_pkg::BW_W-1:0] locked_bandwidth_setting,
   input wire logic auto_bandwidth_enable,
   input wire logic phase_locked,
   input wire logic [2:0] damping_code,
   input wire logic trim_lo_we,
   input wire logic trim_hi_we,
   input wire logic [7:0] trim_byte,
   input wire logic signed [PHASE_W-1:0] phase_in,
   output logic [dpll_trim_pkg::BW_W-1:0] active_bandwidth,
   output dpll_trim_pkg::damp_e damping_factor,
   output logic [dpll_trim_pkg::TRIM_W-1:0] nominal_frequency_trim,
   output logic signed [dpll_trim_pkg::TRIM_W:0] freq_offset_steps,
   output logic signed [PHASE_W-1:0] filtered_phase
);
   import dpll_trim_pkg::*;

   localparam int ACC_W = PHASE_W + PHASE_FRAC + 1;

   ////////////////////////////////////////////////////////////////////////
   // Bandwidth selection and damping
   logic [BW_W-1:0] next_active_bandwidth;
   damp_e next_damping_factor;
   damping_if dif ();

   always_comb begin
      if (auto_bandwidth_enable && !phase_locked) begin
         next_active_bandwidth = acquisition_bandwidth_setting;
      end else begin
         next_active_bandwidth = locked_bandwidth_setting;
      end
   end

   assign dif.bandwidth = next_active_bandwidth;
   assign dif.code = damping_code;
   assign next_damping_factor = dif.factor;

   damping_select u_damping_select (
      .dif(dif)
   );

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         active_bandwidth <= BW_RESET;
         damping_factor <= DAMP_RESET;
      end else begin
         active_bandwidth <= next_active_bandwidth;
         damping_factor <= next_damping_factor;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Calibration word: low byte staged, high byte commits the pair
   logic [7:0] trim_lo_stage;
   logic [7:0] next_trim_lo_stage;
   logic [TRIM_W-1:0] next_trim;
   logic signed [TRIM_W:0] next_offset;

   always_comb begin
      next_trim_lo_stage = trim_lo_stage;
      next_trim = nominal_frequency_trim;
      if (trim_hi_we) begin
         next_trim = {trim_byte, trim_lo_stage};
      end else if (trim_lo_we) begin
         next_trim_lo_stage = trim_byte;
      end
      // Offset in steps of the trim resolution, zero at the reset value
      next_offset = $signed({1'b0, next_trim})
                  - $signed({1'b0, TRIM_RESET});
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         trim_lo_stage <= TRIM_LO_RESET;
         nominal_frequency_trim <= TRIM_RESET;
         freq_offset_steps <= '0;
      end else begin
         trim_lo_stage <= next_trim_lo_stage;
         nominal_frequency_trim <= next_trim;
         freq_offset_steps <= next_offset;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // First order low-pass on input phase, wider bandwidth = faster pole
   logic signed [ACC_W-1:0] phase_acc;
   logic signed [ACC_W-1:0] next_phase_acc;
   logic signed [ACC_W-1:0] phase_err;
   logic [3:0] pole_shift;

   always_comb begin
      pole_shift = BW_SHIFT_BASE - active_bandwidth;
      phase_err = (ACC_W'(phase_in) <<< PHASE_FRAC) - phase_acc;
      next_phase_acc = phase_acc + (phase_err >>> pole_shift);
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         phase_acc <= '0;
         filtered_phase <= '0;
      end else begin
         phase_acc <= next_phase_acc;
         filtered_phase <= next_phase_acc[PHASE_FRAC +: PHASE_W];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   logic trim_written;

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         trim_written <= 1'b0;
      end else if (trim_hi_we) begin
         trim_written <= 1'b1;
      end
   end

   property p_trim_reset_value;
      @(posedge clock) disable iff (!arst_n)
      !trim_written |-> nominal_frequency_trim == 16'h9999;
   endproperty
   a_trim_reset_value: assert property (p_trim_reset_value)
      else $error("trim not at reset value before first write");

   property p_trim_commit;
      @(posedge clock) disable iff (!arst_n)
      trim_hi_we |=> nominal_frequency_trim
         == {$past(trim_byte), $past(trim_lo_stage)};
   endproperty
   a_trim_commit: assert property (p_trim_commit)
      else $error("trim word not formed from both bytes");

   property p_trim_half_write;
      @(posedge clock) disable iff (!arst_n)
      !trim_hi_we |=> $stable(nominal_frequency_trim);
   endproperty
   a_trim_half_write: assert property (p_trim_half_write)
      else $error("trim changed without high byte write");

   property p_trim_offset;
      @(posedge clock) disable iff (!arst_n)
      freq_offset_steps
         == $signed({1'b0, nominal_frequency_trim}) - 17'sd39321;
   endproperty
   a_trim_offset: assert property (p_trim_offset)
      else $error("offset steps do not track trim word");

   property p_trim_full_range;
      @(posedge clock) disable iff (!arst_n)
      trim_hi_we && trim_byte == 8'hFF && trim_lo_stage == 8'hFF
      |=> nominal_frequency_trim == 16'hFFFF
         && freq_offset_steps == 17'sd26214;
   endproperty
   a_trim_full_range: assert property (p_trim_full_range)
      else $error("maximum trim value not accepted");

   property p_acq_bw;
      @(posedge clock) disable iff (!arst_n)
      auto_bandwidth_enable && !phase_locked
      |=> active_bandwidth == $past(acquisition_bandwidth_setting);
   endproperty
   a_acq_bw: assert property (p_acq_bw)
      else $error("acquisition bandwidth not used while unlocked");

   property p_lock_switch;
      @(posedge clock) disable iff (!arst_n)
      auto_bandwidth_enable && $rose(phase_locked)
      |=> active_bandwidth == $past(locked_bandwidth_setting);
   endproperty
   a_lock_switch: assert property (p_lock_switch)
      else $error("bandwidth not narrowed on lock");

   property p_manual_bw;
      @(posedge clock) disable iff (!arst_n)
      !auto_bandwidth_enable
      |=> active_bandwidth == $past(locked_bandwidth_setting);
   endproperty
   a_manual_bw: assert property (p_manual_bw)
      else $error("locked bandwidth not used in manual mode");

   property p_damp_70;
      @(posedge clock) disable iff (!arst_n)
      next_active_bandwidth == 4'h9 && damping_code == 3'h5
      |=> damping_factor == DAMP_20;
   endproperty
   a_damp_70: assert property (p_damp_70)
      else $error("damping 20 not chosen at 70 Hz code 5");

   property p_damp_low;
      @(posedge clock) disable iff (!arst_n)
      next_active_bandwidth < 4'h6 |=> damping_factor == DAMP_5;
   endproperty
   a_damp_low: assert property (p_damp_low)
      else $error("damping not 5 at low bandwidth");

   property p_filter_toward;
      @(posedge clock) disable iff (!arst_n)
      (phase_in > filtered_phase) && $stable(phase_in)
      |=> filtered_phase >= $past(filtered_phase);
   endproperty
   a_filter_toward: assert property (p_filter_toward)
      else $error("filtered phase moved away from input");
endmodule : dpll_loop_and_xo_trim

// file: hw/dpll_trim_pkg.sv
// Constants and types for the DPLL loop and oscillator trim block
package dpll_trim_pkg;
   // Bandwidth codes: 0 to 9 step from 0.1 Hz up to 70 Hz
   localparam int BW_W = 4;
   localparam logic [3:0] BW_CODE_8HZ = 4'h6;
   localparam logic [3:0] BW_CODE_18HZ = 4'h7;
   localparam logic [3:0] BW_CODE_35HZ = 4'h8;
   localparam logic [3:0] BW_CODE_70HZ = 4'h9;
   localparam logic [3:0] BW_RESET = 4'h0;
   // Filter pole: right shift is BW_SHIFT_BASE minus the bandwidth code
   localparam logic [3:0] BW_SHIFT_BASE = 4'hC;
   localparam int PHASE_FRAC = 12;
   // Master oscillator nominal rate, supplied from outside
   localparam real XO_NOMINAL_MHZ = 12.800;
   // Calibration word
   localparam int TRIM_W = 16;
   localparam logic [15:0] TRIM_RESET = 16'h9999;
   localparam real TRIM_STEP_PPM = 0.0196229;
   localparam logic [7:0] TRIM_LO_RESET = 8'h99;
   typedef enum logic [2:0] {
      DAMP_1P2,
      DAMP_2P5,
      DAMP_5,
      DAMP_10,
      DAMP_20
   } damp_e;
   localparam damp_e DAMP_RESET = DAMP_5;
endpackage : dpll_trim_pkg

// file: verif/dpll_loop_and_xo_trim_test.sv
// Self-checking bench for the DPLL loop and oscillator trim block
`timescale 1ns/1ps
`define CHK(act, exp) begin comparisons++; if ((act) !== (exp)) begin \
   num_errors++; \
   $display("[ERR] %0t mismatch got %h exp %h", $time, act, exp); end end
module dpll_loop_and_xo_trim_test;
   import dpll_trim_pkg::*;
   typedef struct packed {logic [2:0] sel; logic [31:0] v;} note_s;
   note_s notes[$];
   note_s n;
   int num_errors = 0;
   int comparisons = 0;
   int seed = 32'hBB9F;
   logic [31:0] r;
   logic in_range;
   logic [3:0] bw;
   logic [2:0] code;
   logic [7:0] staged = 8'h99;
   logic [15:0] trim_exp = 16'h9999;
   logic clock, arst_n, auto_bandwidth_enable, phase_locked;
   logic trim_lo_we, trim_hi_we;
   logic [3:0] acquisition_bandwidth_setting, locked_bandwidth_setting;
   logic [3:0] active_bandwidth;
   logic [2:0] damping_code;
   logic [7:0] trim_byte;
   logic signed [15:0] phase_in, filtered_phase;
   damp_e damping_factor;
   logic [15:0] nominal_frequency_trim;
   logic signed [16:0] freq_offset_steps;
   xo_model osc_u (.clock(clock));
   dpll_loop_and_xo_trim dut_u (.clock(clock), .arst_n(arst_n),
      .acquisition_bandwidth_setting(acquisition_bandwidth_setting),
      .locked_bandwidth_setting(locked_bandwidth_setting),
      .auto_bandwidth_enable(auto_bandwidth_enable),
      .phase_locked(phase_locked), .damping_code(damping_code),
      .trim_lo_we(trim_lo_we), .trim_hi_we(trim_hi_we),
      .trim_byte(trim_byte), .phase_in(phase_in),
      .active_bandwidth(active_bandwidth), .damping_factor(damping_factor),
      .nominal_frequency_trim(nominal_frequency_trim),
      .freq_offset_steps(freq_offset_steps),
      .filtered_phase(filtered_phase));
   ////////////////////////////////////////////////////////////////////////
   function automatic damp_e damp_exp(input logic [3:0] b,
                                      input logic [2:0] c);
      if (c == 3'h1 && b >= 4'h6) return (b == 4'h6) ? DAMP_2P5 : DAMP_1P2;
      if (c == 3'h2 && b >= 4'h7) return DAMP_2P5;
      if (c == 3'h4 && b >= 4'h8) return DAMP_10;
      if (c == 3'h5 && b == 4'h8) return DAMP_10;
      if (c == 3'h5 && b == 4'h9) return DAMP_20;
      return DAMP_5;
   endfunction : damp_exp
   task note(input logic [2:0] s, input logic [31:0] v);
      notes.push_back('{s, v});
   endtask : note
   task wr_byte(input logic lo, input logic hi, input logic [7:0] b);
      @(negedge clock);
      trim_lo_we = lo;
      trim_hi_we = hi;
      trim_byte = b;
      if (lo && !hi) staged = b;
      if (hi) trim_exp = {b, staged};
      note(3'h2, 32'(trim_exp));
      note(3'h3, 32'($signed({1'b0, trim_exp}) - 39321));
   endtask : wr_byte
   task give_verdict();
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : give_verdict
   ////////////////////////////////////////////////////////////////////////
   // Scoreboard: results are settled 20 ns after each rising edge
   always @(posedge clock) begin
      #20;
      while (notes.size() > 0) begin
         n = notes.pop_front();
         case (n.sel)
            3'h0: `CHK(active_bandwidth, n.v[3:0])
            3'h1: `CHK(damping_factor, damp_e'(n.v[2:0]))
            3'h2: `CHK(nominal_frequency_trim, n.v[15:0])
            3'h3: `CHK(freq_offset_steps, n.v[16:0])
            default: begin
               // Filter output window: lower bound high half, upper low half
               in_range = filtered_phase >= $signed(n.v[31:16])
                       && filtered_phase <= $signed(n.v[15:0]);
               `CHK(in_range, 1'b1)
            end
         endcase
      end
   end
   initial begin
      #(1000 * 100);
      num_errors++;
      give_verdict();
   end
   initial begin
      arst_n = 1'b0;
      auto_bandwidth_enable = 1'b0;
      phase_locked = 1'b0;
      acquisition_bandwidth_setting = 4'h0;
      locked_bandwidth_setting = 4'h0;
      damping_code = 3'h3;
      trim_lo_we = 1'b0;
      trim_hi_we = 1'b0;
      trim_byte = 8'h00;
      phase_in = 16'sh0000;
      repeat (3) @(negedge clock);
      arst_n = 1'b1;
      @(negedge clock);
      note(3'h0, 32'h0);
      note(3'h1, 32'(DAMP_5));
      note(3'h2, 32'h9999);
      note(3'h3, 32'h0);
      // Every bandwidth and damping code pair, in random switching modes
      for (int i = 0; i < 80; i++) begin
         @(negedge clock);
         r = $random(seed);
         bw = 4'(i / 8);
         code = 3'(i % 8);
         auto_bandwidth_enable = r[0];
         phase_locked = r[1];
         phase_in = r[31:16];
         acquisition_bandwidth_setting = 4'(r[7:4] % 10);
         locked_bandwidth_setting = 4'(r[11:8] % 10);
         if (r[0] && !r[1]) acquisition_bandwidth_setting = bw;
         else locked_bandwidth_setting = bw;
         damping_code = code;
         note(3'h0, 32'(bw));
         note(3'h1, 32'(damp_exp(bw, code)));
      end
      wr_byte(1'b1, 1'b0, 8'h9A);
      wr_byte(1'b0, 1'b1, 8'h98);
      wr_byte(1'b0, 1'b1, 8'h12);
      wr_byte(1'b1, 1'b1, 8'h55);
      wr_byte(1'b1, 1'b0, 8'h00);
      wr_byte(1'b0, 1'b1, 8'h00);
      wr_byte(1'b1, 1'b0, 8'hFF);
      wr_byte(1'b0, 1'b1, 8'hFF);
      repeat (4) begin
         r = $random(seed);
         wr_byte(1'b1, 1'b0, r[7:0]);
         wr_byte(1'b0, 1'b1, r[15:8]);
      end
      @(negedge clock);
      trim_lo_we = 1'b0;
      trim_hi_we = 1'b0;
      auto_bandwidth_enable = 1'b0;
      locked_bandwidth_setting = BW_CODE_70HZ;
      phase_in = 16'sd100;
      repeat (300) @(negedge clock);
      note(3'h4, {16'sd99, 16'sd101});
      @(negedge clock);
      locked_bandwidth_setting = BW_RESET;
      phase_in = -16'sd100;
      repeat (20) @(negedge clock);
      note(3'h4, {16'sd51, 16'sd32767});
      @(negedge clock);
      // Mid-run reset: trim and staged low byte return to reset values
      arst_n = 1'b0;
      @(negedge clock);
      arst_n = 1'b1;
      staged = 8'h99;
      trim_exp = 16'h9999;
      note(3'h2, 32'h9999);
      note(3'h3, 32'h0);
      wr_byte(1'b0, 1'b1, 8'h12);
      @(negedge clock);
      trim_hi_we = 1'b0;
      @(negedge clock);
      give_verdict();
   end
endmodule : dpll_loop_and_xo_trim_test

// file: verif/xo_model.sv
// Master oscillator model that supplies the block's clock
`timescale 1ns/1ps
module xo_model #(
   parameter real HALF_NS = 50.0
) (
   output logic clock
);
   // Free-running external oscillator, nominal rate scaled for this bench
   initial begin
      clock = 1'b0;
      forever #(HALF_NS) clock = ~clock;
   end
endmodule : xo_model
